// [hdl/dialer_pkg.sv]
package dialer_pkg;

    typedef enum logic [1:0] {
        op_normal,
        op_green,
        op_sleep,
        op_idle
    } op_mode_type;

endpackage

// [hdl/dialer_regs.svh]
`ifndef DIALER_REGS_SVH
`define DIALER_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DIALER_IO_INDEX       8'h16
`define DIALER_IRQ_STAT_INDEX 8'h17
`define DIALER_IRQ_MASK_INDEX 8'h18

// ----------------------------------------------------------------
// Dialer status/control field positions
// ----------------------------------------------------------------
`define HF_REQ_BIT   0
`define HF_OUT_BIT   1
`define HOLD_REQ_BIT 2
`define HOLD_OUT_BIT 3
`define HOOK_BIT     4
`define SELECT_BIT   5
`define BREAK_BIT    6
`define MUTE_BIT     7

// Control bits 7..5 after reset: mute and break floating, line held low
`define DIALER_CTRL_RESET 3'h6

// ----------------------------------------------------------------
// Interrupt event positions
// ----------------------------------------------------------------
`define EV_HOOK_ON  0
`define EV_HOOK_OFF 1
`define EV_HOLD     2
`define EV_HANDS    3
`define EV_COUNT    4
`define EV_RESET    4'h0

`endif

// [hdl/pin_edge_sync.sv]
`timescale 1ns/1ps

module pin_edge_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             core_clk, // System clock
    input  wire logic             rst_b,    // Async reset, active low
    input  wire logic [WIDTH-1:0] pin,      // Raw pin levels
    output logic      [WIDTH-1:0] level,    // Synchronised levels
    output logic      [WIDTH-1:0] rise,     // One-cycle rising edge
    output logic      [WIDTH-1:0] fall      // One-cycle falling edge
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;
    logic [2:0]       warm_q;

    // ----------------------------------------------------------------
    // Two-stage synchroniser, then one stage to find edges
    // ----------------------------------------------------------------
    // No edge until the edge stage holds a real pin sample: an idle-high
    // pin would otherwise show a false rise just after reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            warm_q <= 3'h0;
        end else begin
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                    last_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= pin[i];
                    sync_q[i] <= meta_q[i];
                    last_q[i] <= sync_q[i];
                end
            end
            assign rise[i] = sync_q[i] & ~last_q[i] & warm_q[2];
            assign fall[i] = ~sync_q[i] & last_q[i] & warm_q[2];
        end
    endgenerate

    assign level = sync_q;

endmodule

// [hdl/telephone_dialer_line_control.sv]
// What this block does
// - The speech mute pin is pulled low while control bit 7 is 0 and floats while it is 1.
// - The line break pin is pulled low while control bit 6 is 0, floats at 1, set by software only.
// - While line make select (bit 5) is 0 the line make output stays 0 whatever the inputs do.
// - With select at 1 the line is made unless hook reads 1 and both hand-free and hold are 0.
// - With select at 1, an active hand-free output forces the line make output high.
// - With select at 1, an active hold-line output forces the line make output high.
// - A rising hook edge enters on-hook and raises the dialer interrupt.
// - A falling hook edge enters off-hook, clears hand-free and hold, and raises the interrupt.
// - A low pulse on hold request clears hand-free, toggles hold and raises the interrupt.
// - Hold request is ignored unless the line make output is high.
// - A high pulse on hand-free request clears hold, toggles hand-free, raises the interrupt.
// - Bits 0 to 4 of the dialer register read the levels of the five dialer signals.
// - On-hook with hold active, a hold request edge raises no interrupt.
// - The hook, hand-free and hold machine runs in Normal, Green and Sleep modes.
// - In Idle mode the dialer inputs are not acted upon, except the hook level, which still drives the line make output.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dialer_regs.svh"

module telephone_dialer_line_control (
    input  wire logic                      core_clk,             // 250 MHz system clock
    input  wire logic                      rst_b,                // Async reset, active low
    input  wire dialer_pkg::op_mode_type   op_mode,              // Chip operating mode
    input  wire logic [7:0]                avs_address,          // Byte address
    input  wire logic                      avs_read,             // Read request
    input  wire logic                      avs_write,            // Write request
    input  wire logic [31:0]               avs_writedata,        // Write data
    input  wire logic [3:0]                avs_byteenable,       // Byte lanes
    output logic      [31:0]               avs_readdata,         // Read data
    output logic                           avs_waitrequest,      // Stall, active high
    output logic                           irq,                  // Level interrupt
    input  wire logic                      hook_switch_in,       // Hook switch pin
    input  wire logic                      hold_request_in,      // Hold key, active low pulse
    input  wire logic                      handsfree_request_in, // Hand-free key, high pulse
    output logic                           line_make_out,        // High makes the line
    output logic                           hold_line_out,        // Hold-line state
    output logic                           handsfree_out,        // Hand-free state
    output logic                           speech_mute_out,      // Open drain level, always 0
    output logic                           speech_mute_oe,       // High while pulling low
    output logic                           line_break_out,       // Open drain level, always 0
    output logic                           line_break_oe         // High while pulling low
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    pin_edge_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin      ({handsfree_request_in, hold_request_in, hook_switch_in}),
        .level    (pin_level),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    wire hook_lvl  = pin_level[0];
    wire hold_lvl  = pin_level[1];
    wire hf_lvl    = pin_level[2];
    wire hook_rise = pin_rise[0];
    wire hook_fall = pin_fall[0];
    wire hold_fall = pin_fall[1];
    wire hf_rise   = pin_rise[2];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [2:0]           ctrl_q;
    logic                 hf_q;
    logic                 hf_d;
    logic                 hold_q;
    logic                 hold_d;
    logic [`EV_COUNT-1:0] irq_status_q;
    logic [`EV_COUNT-1:0] irq_status_d;
    logic [`EV_COUNT-1:0] irq_mask_q;
    logic [`EV_COUNT-1:0] read_seen_q;
    logic                 ack_q;
    logic [31:0]          rdata_q;
    logic                 make_q;
    logic                 irq_q;
    logic                 mute_oe_q;
    logic                 break_oe_q;
    logic                 od_low_q;

    // ----------------------------------------------------------------
    // Dialer state machine
    // ----------------------------------------------------------------
    // Idle stops the dialer cells; the other three modes keep them live
    wire active = (op_mode != dialer_pkg::op_idle);

    wire ev_hook_on  = active & hook_rise;
    wire ev_hook_off = active & hook_fall;
    // Hook release wins over a key in the same cycle, hand-free over hold
    wire ev_hands    = active & hf_rise & ~hook_fall;
    wire ev_hold     = active & hold_fall & make_q
                       & ~hook_fall & ~hf_rise;
    wire hold_quiet  = hook_lvl & hold_q;

    wire [`EV_COUNT-1:0] events;
    assign events[`EV_HOOK_ON]  = ev_hook_on;
    assign events[`EV_HOOK_OFF] = ev_hook_off;
    assign events[`EV_HANDS]    = ev_hands;
    assign events[`EV_HOLD]     = ev_hold & ~hold_quiet;

    always_comb begin
        hf_d   = hf_q;
        hold_d = hold_q;
        if (ev_hook_off) begin
            hf_d   = 1'b0;
            hold_d = 1'b0;
        end else if (ev_hands) begin
            hf_d   = ~hf_q;
            hold_d = 1'b0;
        end else if (ev_hold) begin
            hf_d   = 1'b0;
            hold_d = ~hold_q;
        end
    end

    // Line is made by off-hook or either held function, gated by select
    wire make_d = ctrl_q[2'h0] & (~hook_lvl | hf_q | hold_q);

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction

    wire sel_io   = (avs_address == byte_addr(`DIALER_IO_INDEX));
    wire sel_stat = (avs_address == byte_addr(`DIALER_IRQ_STAT_INDEX));
    wire sel_mask = (avs_address == byte_addr(`DIALER_IRQ_MASK_INDEX));

    // One stall cycle per request; read data is caught in that cycle
    wire req       = avs_read | avs_write;
    wire start     = req & ~ack_q;
    wire take_wr   = avs_write & ack_q & avs_byteenable[0];
    wire take_stat = avs_read & ack_q & sel_stat;

    wire [7:0] io_view = {ctrl_q, hook_lvl, hold_q, hold_lvl, hf_q, hf_lvl};
    wire [7:0] rd_sel  = sel_io   ? io_view :
                         sel_stat ? {4'h0, irq_status_q} :
                         sel_mask ? {4'h0, irq_mask_q} : 8'h00;

    // Only bits shown to software are cleared, a newer event survives
    assign irq_status_d = (irq_status_q & ~(take_stat ? read_seen_q : `EV_RESET))
                          | events;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q       <= 1'b0;
            rdata_q     <= 32'h0000_0000;
            read_seen_q <= `EV_RESET;
        end else begin
            ack_q <= start;
            if (start && avs_read) begin
                rdata_q     <= {24'h00_0000, rd_sel};
                read_seen_q <= irq_status_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q     <= `DIALER_CTRL_RESET;
            irq_mask_q <= `EV_RESET;
        end else if (take_wr) begin
            if (sel_io) begin
                ctrl_q <= avs_writedata[`MUTE_BIT:`SELECT_BIT];
            end
            if (sel_mask) begin
                irq_mask_q <= avs_writedata[`EV_COUNT-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Dialer and output registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hf_q         <= 1'b0;
            hold_q       <= 1'b0;
            irq_status_q <= `EV_RESET;
            make_q       <= 1'b0;
            irq_q        <= 1'b0;
            mute_oe_q    <= 1'b0;
            break_oe_q   <= 1'b0;
            od_low_q     <= 1'b0;
        end else begin
            hf_q         <= hf_d;
            hold_q       <= hold_d;
            irq_status_q <= irq_status_d;
            make_q       <= make_d;
            irq_q        <= |(irq_status_q & irq_mask_q);
            mute_oe_q    <= ~ctrl_q[2'h2];
            break_oe_q   <= ~ctrl_q[2'h1];
            od_low_q     <= 1'b0;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = ~ack_q;
    assign irq             = irq_q;
    assign line_make_out   = make_q;
    assign hold_line_out   = hold_q;
    assign handsfree_out   = hf_q;
    assign speech_mute_out = od_low_q;
    assign speech_mute_oe  = mute_oe_q;
    assign line_break_out  = od_low_q;
    assign line_break_oe   = break_oe_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_mute_drive:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ##1 speech_mute_oe == !$past(ctrl_q[2]))
    else $error("speech mute drive does not follow its control bit");

    a_break_drive:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !take_wr ##1 !take_wr |=> $stable(line_break_oe))
    else $error("line break changed without a write");

    a_select_low:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !ctrl_q[0] |=> !line_make_out)
    else $error("line made while select is off");

    a_onhook_break:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ctrl_q[0] && hook_lvl && !hf_q && !hold_q |=> !line_make_out)
    else $error("line made while on-hook and idle");

    a_held_make:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ctrl_q[0] && (hf_q || hold_q || !hook_lvl) |=> line_make_out)
    else $error("line not made while hand-free, hold or off-hook");

    a_hook_on_irq:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        hook_rise && active |=> irq_status_q[`EV_HOOK_ON])
    else $error("hook rise did not raise its status bit");

    a_hook_off_clear:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        hook_fall && active |=> !hf_q && !hold_q && irq_status_q[`EV_HOOK_OFF])
    else $error("hook fall did not clear hand-free and hold");

    a_hold_toggle:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ev_hold |=> hold_q != $past(hold_q) && !hf_q)
    else $error("hold request did not toggle hold-line");

    a_hold_ignored:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        hold_fall && !line_make_out && !hook_fall && !hf_rise |=> $stable(hold_q))
    else $error("hold request acted on a broken line");

    a_hands_toggle:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        hf_rise && active && !hook_fall |=> hf_q != $past(hf_q) && !hold_q)
    else $error("hand-free request did not toggle hand-free");

    a_onhook_quiet:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        hold_fall && hook_lvl && hold_q |-> !events[`EV_HOLD])
    else $error("hold edge raised interrupt while on-hook and held");

    a_idle_frozen:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        op_mode == dialer_pkg::op_idle |=> $stable(hf_q) && $stable(hold_q))
    else $error("dialer state moved in Idle mode");

    a_single_event:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ev_hook_on |=> !ev_hook_on ##1 !ev_hook_on)
    else $error("one hook edge gave more than one event");

    a_irq_level:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ##1 irq == $past(|(irq_status_q & irq_mask_q)))
    else $error("interrupt output does not follow masked status");

    a_wait_one:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        start |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not given after exactly one stall cycle");

    a_hands_sticky:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        events[`EV_HANDS] |=> irq_status_q[`EV_HANDS])
    else $error("hand-free event lost against a status read");

    a_io_capture:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        start && avs_read && sel_io |=> avs_readdata[7:0] == $past(io_view))
    else $error("dialer register read does not show the dialer levels");

endmodule

// [verif/line_partner.sv]
`timescale 1ns/1ps

module line_partner (
    input  wire logic core_clk,             // System clock
    input  wire logic speech_mute_out,      // Mute level from block
    input  wire logic speech_mute_oe,       // Mute pull-down enable
    input  wire logic line_break_out,       // Break level from block
    input  wire logic line_break_oe,        // Break pull-down enable
    output logic      hook_switch_in,       // Hook contact, 1 is on-hook
    output logic      hold_request_in,      // Hold key, idle high
    output logic      handsfree_request_in, // Hand-free key, idle low
    output logic      mute_line,            // Resolved mute wire
    output logic      break_line            // Resolved break wire
);
    // Both wires carry a pull-up, so a released pin reads 1
    assign mute_line  = speech_mute_oe ? speech_mute_out : 1'b1;
    assign break_line = line_break_oe ? line_break_out : 1'b1;

    initial begin
        hook_switch_in       = 1'b0;
        hold_request_in      = 1'b1;
        handsfree_request_in = 1'b0;
    end

    // Pulses of 4 cycles and 8 quiet cycles: wider than the pin path needs
    task automatic press_hf();
        @(posedge core_clk);
        handsfree_request_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        handsfree_request_in <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic press_hold();
        @(posedge core_clk);
        hold_request_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        hold_request_in <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic set_hook(input logic lvl);
        @(posedge core_clk);
        hook_switch_in <= lvl;
        repeat (10) @(posedge core_clk);
    endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
    logic                    core_clk;
    logic                    rst_b;
    dialer_pkg::op_mode_type op_mode;
    logic [7:0]              avs_address;
    logic                    avs_read;
    logic                    avs_write;
    logic [31:0]             avs_writedata;
    logic [3:0]              avs_byteenable;
    logic [31:0]             avs_readdata;
    logic                    avs_waitrequest;
    logic                    irq;
    logic                    hook_switch_in;
    logic                    hold_request_in;
    logic                    handsfree_request_in;
    logic                    line_make_out;
    logic                    hold_line_out;
    logic                    handsfree_out;
    logic                    speech_mute_out;
    logic                    speech_mute_oe;
    logic                    line_break_out;
    logic                    line_break_oe;
    logic                    mute_line;
    logic                    break_line;
    logic [31:0]             rd;
    int                      n_errors;
    int                      tests_run;
    int                      cyc;

    telephone_dialer_line_control dut_u (.*);

    line_partner partner_u (
        .core_clk            (core_clk),
        .speech_mute_out     (speech_mute_out),
        .speech_mute_oe      (speech_mute_oe),
        .line_break_out      (line_break_out),
        .line_break_oe       (line_break_oe),
        .hook_switch_in      (hook_switch_in),
        .hold_request_in     (hold_request_in),
        .handsfree_request_in(handsfree_request_in),
        .mute_line           (mute_line),
        .break_line          (break_line)
    );

    always #2 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // Bus access and closing
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic test_done();
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hang is cut short far beyond the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        op_mode = dialer_pkg::op_normal;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        n_errors = 0;
        tests_run = 0;
        cyc = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge core_clk);
        bus(1'b0, 8'h58, 32'h0);
        `CHK(rd, 32'h000000C4)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000000)
        `CHK(line_make_out, 1'b0)
        `CHK({mute_line, break_line}, 2'h3)
        bus(1'b1, 8'h60, 32'h0F);
        bus(1'b1, 8'h64, 32'hFF);
        bus(1'b0, 8'h64, 32'h0);
        `CHK(rd, 32'h00000000)
        bus(1'b1, 8'h58, 32'h20);
        repeat (3) @(posedge core_clk);
        `CHK({mute_line, break_line}, 2'h0)
        `CHK(line_make_out, 1'b1)
        partner_u.press_hf();
        `CHK({handsfree_out, hold_line_out, irq}, 3'h5)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000008)
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b0)
        bus(1'b0, 8'h58, 32'h0);
        `CHK(rd, 32'h00000026)
        partner_u.press_hold();
        `CHK({handsfree_out, hold_line_out}, 2'h1)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000004)
        partner_u.set_hook(1'b1);
        `CHK({hold_line_out, line_make_out}, 2'h3)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000001)
        bus(1'b0, 8'h58, 32'h0);
        `CHK(rd, 32'h0000003C)
        partner_u.press_hold();
        `CHK({hold_line_out, line_make_out}, 2'h0)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000000)
        partner_u.press_hold();
        `CHK(hold_line_out, 1'b0)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000000)
        partner_u.press_hf();
        `CHK({handsfree_out, line_make_out}, 2'h3)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000008)
        partner_u.set_hook(1'b0);
        `CHK({handsfree_out, hold_line_out}, 2'h0)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000002)
        op_mode <= dialer_pkg::op_green;
        partner_u.press_hf();
        `CHK(handsfree_out, 1'b1)
        op_mode <= dialer_pkg::op_sleep;
        partner_u.press_hf();
        `CHK(handsfree_out, 1'b0)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000008)
        op_mode <= dialer_pkg::op_idle;
        partner_u.press_hf();
        `CHK(handsfree_out, 1'b0)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000000)
        op_mode <= dialer_pkg::op_normal;
        bus(1'b1, 8'h60, 32'h00);
        avs_byteenable <= 4'hE;
        bus(1'b1, 8'h60, 32'h0F);
        avs_byteenable <= 4'hF;
        partner_u.press_hf();
        `CHK({handsfree_out, irq}, 2'h2)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000008)
        bus(1'b0, 8'h5C, 32'h0);
        `CHK(rd, 32'h00000000)
        bus(1'b1, 8'h58, 32'hC0);
        repeat (3) @(posedge core_clk);
        `CHK(line_make_out, 1'b0)
        `CHK({mute_line, break_line}, 2'h3)
        test_done();
    end
endmodule
